// *** design/lssl_steer.sv ***
// Purpose: Steer store data onto byte lanes and align returning load data
// Assumes: Memory side runs on ref_clk_i; one load outstanding at a time
// Notes: Bit 0 of the architectural register is the MSB of the SV vector
`timescale 1ns/1ps
// How it works
// - Byte/half/word to word, byte/half to half slaves
// - Refuse transfers wider than slave, never split
// - Big endian only with MMU above one or reorder
// - BE byte load: offset picks lane, to 24:31
// - BE halfword load: pair lands in 16:31
// - Word load: select 1111, bytes in order
// - LE byte load: mirrored lane, to 24:31
// - LE halfword load: mirrored pair into 16:31
// - BE byte store: 24:31 onto offset lane
// - BE halfword store: 16:31 onto lane pair
// - Word store: select 1111, bytes in order
// - LE byte store: 24:31 onto mirrored lane
// - LE halfword store: 16:31 onto mirrored pair
// - 64-bit path adds long-wide slaves and longs
// - 64-bit BE byte load: 3 offset bits, 56:63
// - 64-bit BE halfword load into 48:63
// - 64-bit BE word load into 32:63
// - Long load: select all ones, bytes in order
// - 64-bit LE loads: mirrored lanes, right-aligned
// - 64-bit BE stores from low-order source bytes
// - Long store: select all ones, bytes in order
// - 64-bit LE stores: mirrored lanes, low bytes
module lssl_steer
    import lssl_pkg::*;
#(
    parameter int DATA_W = LSSL_DATA_W_DEF,
    parameter int MMU_CONFIG_LEVEL = 0,
    parameter int REORDER_OPT = 0
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Request from the load/store unit
    input wire logic req_valid_i,
    input wire logic req_store_i,
    input wire lssl_pkg::lssl_size_t req_size_i,
    input wire lssl_pkg::lssl_size_t slave_size_i,
    input wire logic [$clog2(DATA_W/8)-1:0] req_offset_i,
    input wire logic big_endian_i,
    input wire logic [DATA_W-1:0] store_data_i,
    output logic req_ready_o,
    output logic req_reject_o,
    output logic big_endian_act_o,
    // Memory side lanes
    output logic bus_req_o,
    output logic bus_store_o,
    output logic [DATA_W/8-1:0] lane_sel_o,
    output logic [DATA_W-1:0] bus_wdata_o,
    input wire logic rd_valid_i,
    input wire logic [DATA_W-1:0] rd_data_i,
    // Aligned load result
    output logic load_valid_o,
    output logic [DATA_W-1:0] load_data_o
);
    import lssl_pkg::*;

    localparam int LANES = DATA_W / LSSL_BYTE_W;
    localparam int SH_W = $clog2(LANES) + 1;

    generate
        if (DATA_W != LSSL_DATA_W_NARROW && DATA_W != LSSL_DATA_W_WIDE) begin : g_bad_width
            $error("lssl_steer: DATA_W must be 32 or 64");
        end
        if (MMU_CONFIG_LEVEL < 0) begin : g_bad_mmu
            $error("lssl_steer: MMU_CONFIG_LEVEL must not be negative");
        end
        if (REORDER_OPT != 0 && REORDER_OPT != 1) begin : g_bad_reorder
            $error("lssl_steer: REORDER_OPT must be 0 or 1");
        end
    endgenerate

    // One flag per low-end lane covered by a transfer; higher lanes stay zero
    function automatic logic [LANES-1:0] size_lanes(input lssl_size_t sz);
        logic [LANES-1:0] m;
        m = ~({LANES{1'b1}} << (1 << sz));
        return m;
    endfunction : size_lanes

    typedef enum logic [0:0] {
        LSSL_ST_IDLE = 1'b0,
        LSSL_ST_LOAD = 1'b1
    } lssl_state_t;

    lssl_state_t state_q, state_d;
    logic [SH_W-1:0] ld_shift_q;
    lssl_size_t ld_size_q;
    logic req_ready_q, req_reject_q, be_act_q;
    logic bus_req_q, bus_store_q;
    logic [LANES-1:0] lane_sel_q;
    logic [DATA_W-1:0] bus_wdata_q;
    logic load_valid_q;
    logic [DATA_W-1:0] load_data_q;

    // Big endian is an option only in some core configurations
    localparam logic BE_ALLOWED = (MMU_CONFIG_LEVEL > LSSL_MMU_BE_MIN) || (REORDER_OPT == LSSL_REORDER_BE_ON);
    wire be_eff = big_endian_i & BE_ALLOWED;

    wire [LANES-1:0] map_sel;
    wire [SH_W-1:0] map_shift;
    wire map_legal;

    lssl_lane_map #(
        .LANES(LANES)
    ) u_map (
        .size_i(req_size_i),
        .slave_size_i(slave_size_i),
        .offset_i(req_offset_i),
        .big_endian_i(be_eff),
        .lane_sel_o(map_sel),
        .shift_lanes_o(map_shift),
        .legal_o(map_legal)
    );

    // Accept only while no load is outstanding
    wire take = req_valid_i && (state_q == LSSL_ST_IDLE);
    wire issue = take && map_legal;
    wire refuse = take && !map_legal;
    wire st_issue = issue && req_store_i;
    // Read data is only meaningful while a load is outstanding
    wire ld_return = (state_q == LSSL_ST_LOAD) && rd_valid_i;

    wire [LANES-1:0] ld_keep = size_lanes(ld_size_q);
    wire [DATA_W-1:0] st_shifted;
    wire [DATA_W-1:0] ld_aligned;

    // Store: one mux per lane; the index wraps so an unselected lane never reads out of range
    for (genvar gi = 0; gi < LANES; gi++) begin : g_st_lane
        wire [SH_W-1:0] src_lane = SH_W'(gi) - map_shift;
        wire [SH_W-2:0] src_idx = src_lane[SH_W-2:0];
        assign st_shifted[gi*LSSL_BYTE_W +: LSSL_BYTE_W] =
            map_sel[gi] ? store_data_i[src_idx*LSSL_BYTE_W +: LSSL_BYTE_W] : '0;
    end

    // Load: selected lanes brought down to the low end, rest cleared
    for (genvar gj = 0; gj < LANES; gj++) begin : g_ld_lane
        wire [SH_W-1:0] src_lane = SH_W'(gj) + ld_shift_q;
        wire [SH_W-2:0] src_idx = src_lane[SH_W-2:0];
        assign ld_aligned[gj*LSSL_BYTE_W +: LSSL_BYTE_W] =
            ld_keep[gj] ? rd_data_i[src_idx*LSSL_BYTE_W +: LSSL_BYTE_W] : '0;
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            LSSL_ST_IDLE: begin
                if (issue && !req_store_i) begin
                    state_d = LSSL_ST_LOAD;
                end
            end
            LSSL_ST_LOAD: begin
                if (rd_valid_i) begin
                    state_d = LSSL_ST_IDLE;
                end
            end
            default: begin
                state_d = LSSL_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_q <= LSSL_ST_IDLE;
            ld_shift_q <= '0;
            ld_size_q <= LSSL_SZ_BYTE;
        end else begin
            state_q <= state_d;
            if (issue && !req_store_i) begin
                ld_shift_q <= map_shift;
                ld_size_q <= req_size_i;
            end
        end
    end

    // Next values; every output is a flop so the bus sees clean edges
    wire req_ready_d = (state_d == LSSL_ST_IDLE);
    wire [LANES-1:0] lane_sel_d = issue ? map_sel : '0;
    wire [DATA_W-1:0] bus_wdata_d = st_issue ? st_shifted : '0;
    wire [DATA_W-1:0] load_data_d = ld_return ? ld_aligned : load_data_q;

    // Handshake flops
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            req_ready_q <= LSSL_RDY_RST;
            req_reject_q <= LSSL_RST_LVL;
            be_act_q <= LSSL_RST_LVL;
        end else begin
            req_ready_q <= req_ready_d;
            req_reject_q <= refuse;
            be_act_q <= be_eff;
        end
    end

    // Bus strobe flops; a bus cycle lasts one clock here
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            bus_req_q <= LSSL_RST_LVL;
            bus_store_q <= LSSL_RST_LVL;
        end else begin
            bus_req_q <= issue;
            bus_store_q <= st_issue;
        end
    end

    // Lane and write data flops; idle lanes read as zero
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            lane_sel_q <= '0;
            bus_wdata_q <= '0;
        end else begin
            lane_sel_q <= lane_sel_d;
            bus_wdata_q <= bus_wdata_d;
        end
    end

    // Result flops; the data holds until the next load returns
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            load_valid_q <= LSSL_RST_LVL;
            load_data_q <= '0;
        end else begin
            load_valid_q <= ld_return;
            load_data_q <= load_data_d;
        end
    end

    assign req_ready_o = req_ready_q;
    assign req_reject_o = req_reject_q;
    assign big_endian_act_o = be_act_q;
    assign bus_req_o = bus_req_q;
    assign bus_store_o = bus_store_q;
    assign lane_sel_o = lane_sel_q;
    assign bus_wdata_o = bus_wdata_q;
    assign load_valid_o = load_valid_q;
    assign load_data_o = load_data_q;

endmodule : lssl_steer

// *** design/lssl_pkg.sv ***
// Purpose: Shared constants and types for the load/store lane steering block
// Assumes: Lane 0 is the least significant byte lane of the data bus
// Notes: Size codes double as the log2 of the transfer width in bytes
package lssl_pkg;

    // Transfer and slave sizes, log2 of the byte count
    typedef enum logic [1:0] {
        LSSL_SZ_BYTE = 2'b00,
        LSSL_SZ_HALF = 2'b01,
        LSSL_SZ_WORD = 2'b10,
        LSSL_SZ_LONG = 2'b11
    } lssl_size_t;

    // Bus geometry
    localparam int LSSL_BYTE_W = 8;
    localparam int LSSL_DATA_W_NARROW = 32;
    localparam int LSSL_DATA_W_WIDE = 64;
    localparam int LSSL_DATA_W_DEF = 32;

    // Endian gating thresholds
    localparam int LSSL_MMU_BE_MIN = 1;
    localparam int LSSL_REORDER_BE_ON = 1;

    // Reset values of the output flops
    localparam logic LSSL_RST_LVL = 1'b0;
    localparam logic LSSL_RDY_RST = 1'b1;

endpackage : lssl_pkg

// *** design/lssl_lane_map.sv ***
// Purpose: Decode size, offset, endian mode and slave width into lanes
// Assumes: Purely combinational, used once per request by the top
// Notes: Little endian is the big endian lane start mirrored in the word
`timescale 1ns/1ps
module lssl_lane_map #(
    parameter int LANES = 4
) (
    // Request attributes
    input wire lssl_pkg::lssl_size_t size_i,
    input wire lssl_pkg::lssl_size_t slave_size_i,
    input wire logic [$clog2(LANES)-1:0] offset_i,
    input wire logic big_endian_i,
    // Decoded lanes
    output logic [LANES-1:0] lane_sel_o,
    output logic [$clog2(LANES):0] shift_lanes_o,
    output logic legal_o
);
    import lssl_pkg::*;

    localparam int OFF_W = $clog2(LANES);
    localparam lssl_size_t MAX_SIZE = (LANES == 8) ? LSSL_SZ_LONG : LSSL_SZ_WORD;

    wire [OFF_W:0] nbytes = (OFF_W + 1)'(1) << size_i;
    wire [OFF_W:0] off_ext = {1'b0, offset_i};
    wire [OFF_W:0] lanes_c = (OFF_W + 1)'(LANES);
    // Little endian counts lanes from the far end of the bus
    wire [OFF_W:0] start = big_endian_i ? off_ext : lanes_c - nbytes - off_ext;
    wire [OFF_W:0] shift = lanes_c - start - nbytes;
    wire aligned = (off_ext & (nbytes - (OFF_W + 1)'(1))) == '0;
    // Nothing wider than the slave or the bus; no splitting into smaller cycles
    wire fits = (size_i <= slave_size_i) && (size_i <= MAX_SIZE) && (slave_size_i <= MAX_SIZE);
    wire [LANES:0] ones = ((LANES + 1)'(1) << nbytes) - (LANES + 1)'(1);

    assign legal_o = fits && aligned;
    assign shift_lanes_o = legal_o ? shift : '0;
    assign lane_sel_o = legal_o ? (ones[LANES-1:0] << shift) : '0;

endmodule : lssl_lane_map

// *** testbench/lssl_steer_props.sv ***
// Purpose: Port-level checks of lane steering
// Assumes: 32-bit path with big endian allowed
// Notes: Lane checks use the 4-lane figures only
`timescale 1ns/1ps
module lssl_steer_props
    import lssl_pkg::*;
#(
    parameter int DATA_W = 32
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Request side
    input wire logic req_valid_i,
    input wire logic req_store_i,
    input wire lssl_pkg::lssl_size_t req_size_i,
    input wire lssl_pkg::lssl_size_t slave_size_i,
    input wire logic [$clog2(DATA_W/8)-1:0] req_offset_i,
    input wire logic big_endian_i,
    input wire logic [DATA_W-1:0] store_data_i,
    input wire logic req_ready_o,
    input wire logic req_reject_o,
    input wire logic big_endian_act_o,
    // Bus side
    input wire logic bus_req_o,
    input wire logic [DATA_W/8-1:0] lane_sel_o,
    input wire logic [DATA_W-1:0] bus_wdata_o,
    input wire logic rd_valid_i,
    input wire logic load_valid_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    wire take = req_valid_i && req_ready_o;
    wire byte_st = take && req_store_i && req_size_i == LSSL_SZ_BYTE && slave_size_i != LSSL_SZ_LONG;
    wire word_ok = take && req_size_i == LSSL_SZ_WORD && slave_size_i == LSSL_SZ_WORD && req_offset_i == 2'h0;
    sequence one_pulse;
        load_valid_o ##1 !load_valid_o;
    endsequence
    one_answer_a: assert property (take |=> bus_req_o != req_reject_o) else $error("no single answer");
    too_wide_a: assert property (take && req_size_i > slave_size_i |=> req_reject_o) else $error("wide taken");
    word_sel_a: assert property (word_ok |=> lane_sel_o == 4'hF) else $error("word lanes");
    word_data_a: assert property (word_ok && req_store_i |=> bus_wdata_o == $past(store_data_i)) else $error("word");
    be_byte_a: assert property (byte_st |=> !big_endian_act_o || lane_sel_o == 4'h8 >> $past(req_offset_i))
        else $error("be");
    le_byte_a: assert property (byte_st |=> big_endian_act_o || lane_sel_o == 4'h1 << $past(req_offset_i))
        else $error("le");
    result_pulse_a: assert property (rd_valid_i && !req_ready_o |=> one_pulse) else $error("no result");
    idle_lanes_a: assert property (!bus_req_o |-> lane_sel_o == '0 && bus_wdata_o == '0) else $error("idle lanes");
endmodule : lssl_steer_props
bind lssl_steer lssl_steer_props #(.DATA_W(DATA_W)) i_props (.ref_clk_i, .srst_i, .req_valid_i, .req_store_i,
    .req_size_i, .slave_size_i, .req_offset_i, .big_endian_i, .store_data_i, .req_ready_o, .req_reject_o, .big_endian_act_o,
    .bus_req_o, .lane_sel_o, .bus_wdata_o, .rd_valid_i, .load_valid_o);

// *** testbench/lssl_mem_model.sv ***
// Purpose: Word-wide memory slave answering loads
// Assumes: One load outstanding at a time
// Notes: Idle read bus toggles so stale data never looks valid
`timescale 1ns/1ps
module lssl_mem_model (
    input wire logic ref_clk_i,
    input wire logic bus_req_i,
    input wire logic bus_store_i,
    output logic rd_valid_o,
    output logic [31:0] rd_data_o
);
    integer seed = 16;
    integer wait_n = -1;
    initial begin
        rd_valid_o = 1'b0;
        rd_data_o = 32'h0;
    end
    // Each load answered once, never split; stores get no answer
    always @(posedge ref_clk_i) begin
        rd_valid_o <= 1'b0;
        rd_data_o <= ~rd_data_o;
        if (bus_req_i && !bus_store_i) wait_n = {$random(seed)} % 3;
        if (wait_n == 0) begin
            rd_valid_o <= 1'b1;
            rd_data_o <= $random(seed);
        end
        if (wait_n >= 0) wait_n = wait_n - 1;
    end
endmodule : lssl_mem_model

// *** testbench/test_lssl_steer.sv ***
// Purpose: Random requests compared with a lane model
// Assumes: 32-bit path, big endian allowed by reorder option
// Notes: Requests are spaced, back-to-back stores not covered
`timescale 1ns/1ps
module test_lssl_steer;
    import lssl_pkg::*;
    logic ref_clk_i = 0, srst_i = 1, req_valid_i = 0, req_store_i = 0, big_endian_i = 0;
    logic req_ready_o, req_reject_o, big_endian_act_o, bus_req_o, bus_store_o, load_valid_o, rd_valid_i, be_act_le;
    logic [1:0] req_offset_i = 0;
    logic [3:0] lane_sel_o, sel, sel_le, le_sel;
    logic [31:0] store_data_i = 0, bus_wdata_o, rd_data_i, load_data_o, rd, msk, r, wdata_le, ld_le;
    lssl_size_t req_size_i = LSSL_SZ_BYTE, slave_size_i = LSSL_SZ_BYTE;
    integer seed = 16, mismatches = 0, cmp_count = 0, n, s, sh, legal, sh_le;
    always #50 ref_clk_i = ~ref_clk_i;
    lssl_steer #(.REORDER_OPT(1)) i_dut (.ref_clk_i, .srst_i, .req_valid_i, .req_store_i, .req_size_i,
        .slave_size_i, .req_offset_i, .big_endian_i, .store_data_i, .req_ready_o, .req_reject_o,
        .big_endian_act_o, .bus_req_o, .bus_store_o, .lane_sel_o, .bus_wdata_o, .rd_valid_i, .rd_data_i,
        .load_valid_o, .load_data_o);
    // Default build: big endian not allowed, so requests must steer little endian
    lssl_steer i_dut_le (.ref_clk_i, .srst_i, .req_valid_i, .req_store_i, .req_size_i,
        .slave_size_i, .req_offset_i, .big_endian_i, .store_data_i, .req_ready_o(), .req_reject_o(),
        .big_endian_act_o(be_act_le), .bus_req_o(), .bus_store_o(), .lane_sel_o(sel_le), .bus_wdata_o(wdata_le),
        .rd_valid_i, .rd_data_i, .load_valid_o(), .load_data_o(ld_le));
    lssl_mem_model i_mem (.ref_clk_i, .bus_req_i(bus_req_o), .bus_store_i(bus_store_o), .rd_valid_o(rd_valid_i),
        .rd_data_o(rd_data_i));
    task check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    task results;
        if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    initial begin
        #1000000;
        mismatches++;
        results();
    end
    initial begin
        repeat (5) @(posedge ref_clk_i);
        srst_i <= 0;
        repeat (300) begin
            @(posedge ref_clk_i);
            r = $random(seed);
            req_valid_i <= 1;
            req_store_i <= r[0];
            req_size_i <= lssl_size_t'(r[2:1]);
            slave_size_i <= lssl_size_t'(r[4:3]);
            req_offset_i <= r[6:5];
            big_endian_i <= r[7];
            store_data_i <= $random(seed);
            @(posedge ref_clk_i);
            req_valid_i <= 0;
            @(negedge ref_clk_i);
            n = 1 << req_size_i;
            legal = req_size_i <= slave_size_i && slave_size_i <= LSSL_SZ_WORD && req_offset_i % n == 0;
            s = big_endian_i ? req_offset_i : 4 - n - req_offset_i;
            sh = 8 * (4 - s - n);
            msk = (32'h1 << 8 * n) - 32'h1;
            sel = ((4'h1 << n) - 4'h1) << (4 - s - n);
            sh_le = 8 * req_offset_i;
            le_sel = ((4'h1 << n) - 4'h1) << req_offset_i;
            check(bus_req_o, legal);
            check(bus_store_o, legal && req_store_i);
            check(req_ready_o, !(legal && !req_store_i));
            check(be_act_le, 0);
            check(req_reject_o, !legal);
            check(big_endian_act_o, big_endian_i);
            if (legal) begin
                check(lane_sel_o, sel);
                check(bus_wdata_o, req_store_i ? (store_data_i & msk) << sh : 32'h0);
                check(sel_le, le_sel);
                check(wdata_le, req_store_i ? (store_data_i & msk) << sh_le : 32'h0);
            end
            if (legal && !req_store_i) begin
                for (int k = 0; k < 10 && load_valid_o !== 1'b1; k++) begin
                    if (rd_valid_i === 1'b1) rd = rd_data_i;
                    @(negedge ref_clk_i);
                end
                check(load_valid_o, 1);
                check(load_data_o, (rd >> sh) & msk);
                check(ld_le, (rd >> sh_le) & msk);
            end
        end
        results();
    end
endmodule : test_lssl_steer
